//--- src/sfb_map.svh
/*
 constants for the processor flags register and the banked data memory partition.
 assumes inclusion by the sfb core and its checker only.
*/
`ifndef SFB_MAP_SVH
`define SFB_MAP_SVH
`define SFB_BANK_COUNT 32
`define SFB_BANK_BYTES 128
`define SFB_CORE_LAST 7'h0b
`define SFB_FLAGS_OFS 7'h03
`define SFB_BSR_OFS 7'h08
`define SFB_PERI_FIRST 7'h0c
`define SFB_PERI_LAST 7'h1f
`define SFB_GPR_FIRST 7'h20
`define SFB_GPR_LAST 7'h6f
`define SFB_GPR_BYTES 80
`define SFB_COMMON_FIRST 7'h70
`define SFB_COMMON_BYTES 16
`define SFB_LIN_BASE 16'h2000
`define SFB_BIT_EXPIRY 4
`define SFB_BIT_SLEEP 3
`define SFB_BIT_ZERO 2
`define SFB_BIT_NIBBLE 1
`define SFB_BIT_CARRY 0
`define SFB_FLAGS_RESET 8'h18
`define SFB_FLAGS_MASK 8'h1f
`endif

//--- src/sfb_pkg.sv
/*
 types shared by the flags and bank partition block.
 assumes sfb_map.svh holds all numeric constants.
*/
package sfb_pkg;
   typedef enum logic [2:0] {
      SFB_OP_NONE, SFB_OP_ADD, SFB_OP_SUB, SFB_OP_LOGIC, SFB_OP_CLEAR, SFB_OP_PLAIN
   } sfb_op_type;
   typedef enum logic [2:0] {
      SFB_AREA_CORE, SFB_AREA_PERI, SFB_AREA_GPR, SFB_AREA_COMMON, SFB_AREA_NONE
   } sfb_area_type;
   typedef struct packed {
      logic wr_en;
      logic [6:0] addr;
      logic [7:0] wdata;
      sfb_op_type op;
      logic [7:0] opa;
      logic [7:0] opb;
   } sfb_exec_type;
   typedef struct packed {
      logic lin_en;
      logic lin_wr;
      logic [15:0] lin_addr;
      logic [7:0] lin_wdata;
   } sfb_lin_type;
   typedef struct packed {
      logic watchdog_clear;
      logic sleep;
      logic timeout;
   } sfb_hw_event_type;
endpackage

//--- src/sfb_core.sv
/*
 processor flags register with masked instruction writes, bank select,
 area decode and banked/common/linear general ram.
 assumes the core's execute stage drives one request a cycle on clk_sys_i.
*/
`timescale 1ns/1ns
`include "sfb_map.svh"
module sfb_core (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // execute stage request
   input wire sfb_pkg::sfb_exec_type exec_i,
   // linear access through indirect pointer
   input wire sfb_pkg::sfb_lin_type lin_i,
   // hardware reset-cause events
   input wire sfb_pkg::sfb_hw_event_type hw_evt_i,
   // results
   output logic [7:0] processor_flags_o,
   output logic [4:0] bank_select_o,
   output logic [7:0] rdata_o,
   output logic [7:0] lin_rdata_o,
   output logic [7:0] alu_result_o,
   output logic [2:0] area_o
);
   import sfb_pkg::*;

   localparam int GPR_WORDS = `SFB_BANK_COUNT * `SFB_GPR_BYTES;

   logic [7:0] processor_flags_q;
   logic [4:0] bank_select_q;
   logic [7:0] rdata_q, lin_rdata_q, alu_result_q;
   logic [2:0] area_q;
   logic [7:0] gpr_mem [0:GPR_WORDS-1];
   logic [7:0] common_mem [0:`SFB_COMMON_BYTES-1];

   // ALU result and flags
   logic [8:0] sum9;
   logic [4:0] sum5;
   logic [7:0] res;
   logic [7:0] opb_eff;
   logic arith, flag_op, hit_flags, hit_bank;
   logic [7:0] core_rdata;
   logic [11:0] gpr_base;
   sfb_area_type area;
   logic [11:0] gpr_idx;
   logic [11:0] lin_idx;
   logic lin_ok;

   always_comb begin
      // subtract by adding the complement plus one
      opb_eff = (exec_i.op == SFB_OP_SUB) ? ~exec_i.opb : exec_i.opb;
      sum9 = {1'b0, exec_i.opa} + {1'b0, opb_eff} + {8'h00, exec_i.op == SFB_OP_SUB};
      sum5 = {1'b0, exec_i.opa[3:0]} + {1'b0, opb_eff[3:0]} + {4'h0, exec_i.op == SFB_OP_SUB};
      arith = (exec_i.op == SFB_OP_ADD) || (exec_i.op == SFB_OP_SUB);
      flag_op = arith || (exec_i.op == SFB_OP_LOGIC) || (exec_i.op == SFB_OP_CLEAR);
      case (exec_i.op)
         SFB_OP_ADD, SFB_OP_SUB: res = sum9[7:0];
         SFB_OP_CLEAR: res = 8'h00;
         default: res = exec_i.wdata;
      endcase
      // flags register decoded at the same offset in every bank
      hit_flags = exec_i.wr_en && (exec_i.addr == `SFB_FLAGS_OFS);
      hit_bank = exec_i.wr_en && (exec_i.addr == `SFB_BSR_OFS);
      // core register read mux, unimplemented core offsets read zero
      if (exec_i.addr == `SFB_FLAGS_OFS) begin
         core_rdata = processor_flags_q & `SFB_FLAGS_MASK;
      end else if (exec_i.addr == `SFB_BSR_OFS) begin
         core_rdata = {3'h0, bank_select_q};
      end else begin
         core_rdata = 8'h00;
      end
   end

   // bank area decode
   always_comb begin
      if (exec_i.addr <= `SFB_CORE_LAST) begin
         area = SFB_AREA_CORE;
      end else if (exec_i.addr <= `SFB_PERI_LAST) begin
         area = SFB_AREA_PERI;
      end else if (exec_i.addr <= `SFB_GPR_LAST) begin
         area = SFB_AREA_GPR;
      end else begin
         area = SFB_AREA_COMMON;
      end
      // each bank owns one slice of the shared general ram
      gpr_base = 12'(bank_select_q * `SFB_GPR_BYTES);
      gpr_idx = gpr_base + 12'(exec_i.addr - `SFB_GPR_FIRST);
      // linear window ignores bank select
      lin_idx = 12'(lin_i.lin_addr - `SFB_LIN_BASE);
      lin_ok = (lin_i.lin_addr >= `SFB_LIN_BASE) && (lin_i.lin_addr < `SFB_LIN_BASE + 16'(GPR_WORDS));
   end

   // flags register
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         processor_flags_q <= `SFB_FLAGS_RESET;
      end else begin
         if (hit_flags) begin
            // upper bits unimplemented, expiry and sleep bits never written
            if (!flag_op) begin
               processor_flags_q[2:0] <= res[2:0];
            end
            processor_flags_q[7:5] <= 3'h0;
            if (exec_i.op == SFB_OP_CLEAR) begin
               // keep nibble and carry, set zero
               processor_flags_q[`SFB_BIT_ZERO] <= 1'b1;
               processor_flags_q[1:0] <= processor_flags_q[1:0];
            end
         end
         // flag results override any written value
         if (flag_op && exec_i.op != SFB_OP_CLEAR) begin
            processor_flags_q[`SFB_BIT_ZERO] <= (res == 8'h00);
            if (arith) begin
               processor_flags_q[`SFB_BIT_CARRY] <= sum9[8];
               processor_flags_q[`SFB_BIT_NIBBLE] <= sum5[4];
            end
         end else if (exec_i.op == SFB_OP_CLEAR && exec_i.wr_en) begin
            processor_flags_q[`SFB_BIT_ZERO] <= 1'b1;
         end
         // hardware-only reset cause bits
         if (hw_evt_i.timeout) begin
            processor_flags_q[`SFB_BIT_EXPIRY] <= 1'b0;
         end else if (hw_evt_i.watchdog_clear || hw_evt_i.sleep) begin
            processor_flags_q[`SFB_BIT_EXPIRY] <= 1'b1;
         end
         if (hw_evt_i.watchdog_clear) begin
            processor_flags_q[`SFB_BIT_SLEEP] <= 1'b1;
         end else if (hw_evt_i.sleep) begin
            processor_flags_q[`SFB_BIT_SLEEP] <= 1'b0;
         end
      end
   end

   // bank select register
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         bank_select_q <= 5'h00;
      end else if (hit_bank) begin
         // only the five bank bits are held, higher written bits drop
         bank_select_q <= res[4:0];
      end
   end

   // general ram writes; memories need no reset
   // the linear port wins if both ports hit one word in a cycle
   always_ff @(posedge clk_sys_i) begin
      if (exec_i.wr_en && area == SFB_AREA_GPR) begin
         gpr_mem[gpr_idx] <= res;
      end
      if (lin_i.lin_en && lin_i.lin_wr && lin_ok) begin
         gpr_mem[lin_idx] <= lin_i.lin_wdata;
      end
   end

   // common ram writes, same storage whatever the bank
   always_ff @(posedge clk_sys_i) begin
      if (exec_i.wr_en && area == SFB_AREA_COMMON) begin
         common_mem[exec_i.addr[3:0]] <= res;
      end
   end

   // banked read, unimplemented reads zero
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         rdata_q <= 8'h00;
      end else begin
         case (area)
            SFB_AREA_GPR: rdata_q <= gpr_mem[gpr_idx];
            SFB_AREA_COMMON: rdata_q <= common_mem[exec_i.addr[3:0]];
            SFB_AREA_CORE: rdata_q <= core_rdata;
            // peripheral registers live outside this block and read as zero here
            SFB_AREA_PERI: rdata_q <= 8'h00;
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // linear read port, bank select plays no part
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         lin_rdata_q <= 8'h00;
      end else begin
         lin_rdata_q <= lin_ok ? gpr_mem[lin_idx] : 8'h00;
      end
   end

   // op result and decoded area, for observation
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         alu_result_q <= 8'h00;
         area_q <= 3'h0;
      end else begin
         alu_result_q <= res;
         area_q <= area;
      end
   end

   assign processor_flags_o = processor_flags_q;
   assign bank_select_o = bank_select_q;
   assign rdata_o = rdata_q;
   assign lin_rdata_o = lin_rdata_q;
   assign alu_result_o = alu_result_q;
   assign area_o = area_q;
endmodule

//--- dv/sfb_core_asserts.sv
/* checker for sfb_core: flag masking, alu flags, reset causes, area decode.
   assumes a bind onto sfb_core and a single clock. */
`timescale 1ns/1ns
`include "sfb_map.svh"
module sfb_core_asserts (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // watched ports
   input wire sfb_pkg::sfb_exec_type exec_i,
   input wire sfb_pkg::sfb_hw_event_type hw_evt_i,
   input wire logic [7:0] processor_flags_o,
   input wire logic [7:0] alu_result_o,
   input wire logic [2:0] area_o
);
   import sfb_pkg::*;
   logic [7:0] b;
   logic ci;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [10:0] exp_alu;
   logic [2:0] zone;
   logic fl_wr;
   // subtract as add of the two's complement
   assign ci = exec_i.op == SFB_OP_SUB;
   assign b = ci ? ~exec_i.opb : exec_i.opb;
   assign sum = {1'b0, exec_i.opa} + {1'b0, b} + {8'h00, ci};
   assign nib = {1'b0, exec_i.opa[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
   assign exp_alu = {sum[7:0] == 8'h00, nib[4], sum[8], sum[7:0]};
   assign zone = exec_i.addr <= `SFB_CORE_LAST ? 3'h0 : exec_i.addr <= `SFB_PERI_LAST ? 3'h1 :
      exec_i.addr <= `SFB_GPR_LAST ? 3'h2 : 3'h3;
   assign fl_wr = exec_i.wr_en && exec_i.addr == `SFB_FLAGS_OFS;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   a_upper_bits_zero: assert property (processor_flags_o[7:5] == 3'h0)
      else $error("flags upper bits not zero");
   a_cause_bits_locked: assert property (hw_evt_i == 3'h0 |=> $stable(processor_flags_o[4:3]))
      else $error("cause bits changed without event");
   a_timeout_clears: assert property (hw_evt_i.timeout |=> !processor_flags_o[4])
      else $error("timeout left expiry set");
   a_sleep_marks: assert property (hw_evt_i == 3'b010 |=> processor_flags_o[4:3] == 2'b10)
      else $error("sleep cause bits wrong");
   a_wdc_sets: assert property (hw_evt_i == 3'b100 |=> processor_flags_o[4:3] == 2'b11)
      else $error("watchdog clear cause bits wrong");
   a_alu_flags: assert property (exec_i.op inside {SFB_OP_ADD, SFB_OP_SUB} |=>
      {processor_flags_o[2:0], alu_result_o} == $past(exp_alu)) else $error("alu flags or result wrong");
   a_clear_flags: assert property (fl_wr && exec_i.op == SFB_OP_CLEAR && hw_evt_i == 3'h0 |=>
      processor_flags_o == (($past(processor_flags_o) & 8'h1b) | 8'h04)) else $error("clear of flags wrong");
   a_plain_masked: assert property (fl_wr && exec_i.op == SFB_OP_PLAIN && hw_evt_i == 3'h0 |=>
      processor_flags_o == (($past(processor_flags_o) & 8'h18) | ($past(exec_i.wdata) & 8'h07)))
      else $error("plain write of flags wrong");
   a_logic_zero_only: assert property (exec_i.op == SFB_OP_LOGIC && hw_evt_i == 3'h0 |=>
      processor_flags_o == (($past(processor_flags_o) & 8'h1b) | (($past(exec_i.wdata) == 8'h00) ? 8'h04 : 8'h00)))
      else $error("logic op touched carry or nibble");
   a_area_decode: assert property (##1 area_o == $past(zone))
      else $error("area decode wrong");
   c_clear: cover property (fl_wr && exec_i.op == SFB_OP_CLEAR);
   c_timeout: cover property (hw_evt_i.timeout);
   c_borrow: cover property (exec_i.op == SFB_OP_SUB ##1 !processor_flags_o[0]);
endmodule
bind sfb_core sfb_core_asserts u_chk (.clk_sys_i, .sys_rst_i, .exec_i, .hw_evt_i, .processor_flags_o,
   .alu_result_o, .area_o);

//--- dv/test_status_flags_and_bank_layout.sv
/* bench for sfb_core: flag writes, alu flags, reset causes, banks.
   assumes the checker is bound in and the core answers one cycle later. */
`timescale 1ns/1ns
module test_status_flags_and_bank_layout;
   import sfb_pkg::*;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   sfb_exec_type exec_i = '0;
   sfb_lin_type lin_i = '0;
   sfb_hw_event_type hw_evt_i = '0;
   logic [7:0] fl, rdata_o, lin_rdata_o, alu;
   logic [4:0] bank;
   logic [2:0] area;
   int num_errors = 0;
   int samples_checked = 0;
   sfb_core dut (.clk_sys_i, .sys_rst_i, .exec_i, .lin_i, .hw_evt_i, .processor_flags_o(fl),
      .bank_select_o(bank), .rdata_o, .lin_rdata_o, .alu_result_o(alu), .area_o(area));
   initial begin
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // reads use op none with no write, so no stray store
   task automatic op(input sfb_op_type o, input logic [6:0] a, input logic [7:0] w = 8'h00,
      input logic [7:0] x = 8'h00, input logic [7:0] y = 8'h00);
      @(negedge clk_sys_i);
      exec_i = '{o != SFB_OP_NONE, a, w, o, x, y};
      @(negedge clk_sys_i);
      exec_i = '0;
   endtask
   task automatic alu_op(input sfb_op_type o, input logic [7:0] x, y, ef, er);
      op(o, 7'h10, 8'h55, x, y);
      check("flags", ef, fl);
      check("alu", er, alu);
   endtask
   task automatic evt(input sfb_hw_event_type e, input logic [7:0] ef);
      @(negedge clk_sys_i);
      hw_evt_i = e;
      @(negedge clk_sys_i);
      hw_evt_i = '0;
      check("flags", ef, fl);
   endtask
   task automatic lin(input logic wr, input logic [15:0] a, input logic [7:0] w = 8'h00);
      @(negedge clk_sys_i);
      lin_i = '{1'b1, wr, a, w};
      @(negedge clk_sys_i);
      lin_i = '0;
   endtask
   task automatic flag_writes;
      op(SFB_OP_PLAIN, 7'h03, 8'hff);
      check("flags", 8'h1f, fl);
      op(SFB_OP_PLAIN, 7'h03, 8'h01);
      check("flags", 8'h19, fl);
      op(SFB_OP_CLEAR, 7'h03);
      check("flags", 8'h1d, fl);
      op(SFB_OP_NONE, 7'h03);
      check("rdata", 8'h1d, rdata_o);
   endtask
   task automatic alu_flags;
      op(SFB_OP_ADD, 7'h03, 8'h55, 8'hff, 8'h01);
      check("flags", 8'h1f, fl);
      op(SFB_OP_LOGIC, 7'h03, 8'h06);
      check("flags", 8'h1b, fl);
      alu_op(SFB_OP_SUB, 8'h05, 8'h03, 8'h1b, 8'h02);
      alu_op(SFB_OP_SUB, 8'h03, 8'h05, 8'h18, 8'hfe);
      alu_op(SFB_OP_ADD, 8'h08, 8'h08, 8'h1a, 8'h10);
   endtask
   task automatic cause_bits;
      evt(3'b001, 8'h0a);
      evt(3'b010, 8'h12);
      evt(3'b100, 8'h1a);
   endtask
   task automatic banks;
      op(SFB_OP_PLAIN, 7'h08, 8'h1f);
      check("bank", 8'h1f, {3'h0, bank});
      op(SFB_OP_PLAIN, 7'h70, 8'ha5);
      op(SFB_OP_PLAIN, 7'h08, 8'h00);
      op(SFB_OP_PLAIN, 7'h20, 8'h11);
      op(SFB_OP_NONE, 7'h70);
      check("common", 8'ha5, rdata_o);
      op(SFB_OP_PLAIN, 7'h08, 8'h01);
      op(SFB_OP_PLAIN, 7'h20, 8'h22);
      lin(1'b0, 16'h2000);
      check("lin", 8'h11, lin_rdata_o);
      lin(1'b0, 16'h2050);
      check("lin", 8'h22, lin_rdata_o);
      lin(1'b1, 16'h2051, 8'h33);
      op(SFB_OP_NONE, 7'h21);
      check("gpr", 8'h33, rdata_o);
   endtask
   task automatic areas;
      op(SFB_OP_NONE, 7'h0b);
      check("area", 8'h00, {5'h00, area});
      check("rdata", 8'h00, rdata_o);
      op(SFB_OP_NONE, 7'h0c);
      check("area", 8'h01, {5'h00, area});
      check("rdata", 8'h00, rdata_o);
      op(SFB_OP_NONE, 7'h1f);
      check("area", 8'h01, {5'h00, area});
      op(SFB_OP_NONE, 7'h6f);
      check("area", 8'h02, {5'h00, area});
      op(SFB_OP_NONE, 7'h7f);
      check("area", 8'h03, {5'h00, area});
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      sys_rst_i = 1'b0;
      check("flags", 8'h18, fl);
      flag_writes();
      alu_flags();
      cause_bits();
      banks();
      areas();
      print_verdict();
   end
endmodule
